//--- src/ixo_pkg.sv
// constants for the indexed literal offset operand decoder
package ixo_pkg;
    // data space
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 4096;
    // opcode fields
    localparam int OPC_A_BIT = 8;
    localparam int OPC_D_BIT = 9;
    localparam int OPC_F_LSB = 0;
    localparam int OPC_F_MSB = 7;
    localparam int OPC_B_LSB = 9;
    localparam int OPC_B_MSB = 11;
    // opcode patterns
    localparam logic [5:0] OPC_ADD_HI = 6'h09;
    localparam logic [3:0] OPC_BSET_HI = 4'h8;
    localparam logic [6:0] OPC_FILL_HI = 7'h34;
    // operand space limits
    localparam logic [7:0] OFFSET_MAX = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT_STD = 8'h80;
    localparam logic [7:0] ACCESS_SPLIT_EXT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [7:0] FILL_VALUE = 8'hff;
    // status flag positions
    localparam int ST_C = 0;
    localparam int ST_DIG = 1;
    localparam int ST_Z = 2;
    localparam int ST_OVF = 3;
    localparam int ST_N = 4;
    localparam int ST_W = 5;
    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic EXT_RST = 1'b0;
endpackage

//--- src/ixo_data_ram.sv
// 4096-byte data memory with two read ports and one write port
`timescale 1ns/1ps
module ixo_data_ram
    import ixo_pkg::*;
(
    // clock
    input wire logic mclk_i,
    // write port
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] waddr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    // execute read port
    input wire logic [ADDR_W-1:0] raddr_a_i,
    output logic [DATA_W-1:0] rdata_a_o,
    // observation read port
    input wire logic [ADDR_W-1:0] raddr_b_i,
    output logic [DATA_W-1:0] rdata_b_o
);
    logic [DATA_W-1:0] mem_q [MEM_DEPTH];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    assign rdata_a_o = mem_q[raddr_a_i];
    assign rdata_b_o = mem_q[raddr_b_i];
endmodule

//--- src/ixo_decode.sv
// operand decode and execute for add, bit set and fill in indexed literal offset mode
// Operation
// - with the extended set on and a=0, a field of 5Fh or less is an offset 0..95, not an address.
// - in extended mode with a=0 and field <= 5Fh, the address is the frame pointer plus offset.
// - with the extended set off, the field is an access-bank address (a=0) or bank-select (a=1).
// - opcode 0010 01d0 adds the accumulator to the addressed byte in one cycle.
// - the add sum goes to the accumulator when d=0 and back to the data byte when d=1.
// - the add updates the N, overflow, C, digit carry and Z flags; bit set and fill keep them.
// - opcode 1000 bbb0 sets bit b of the addressed byte in one cycle, other bits kept.
// - opcode 0110 1000 writes FFh to the addressed byte in one cycle.
// - the extended-set configuration bit resets to 0 (off); 1 enables the extended behaviour.
`timescale 1ns/1ps
module ixo_decode
    import ixo_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // configuration
    input wire logic extended_set_config_bit_i,
    // instruction from the decoder
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    // address sources
    input wire logic [ADDR_W-1:0] stack_frame_pointer_i,
    input wire logic [3:0] bank_select_register_i,
    // accumulator preload
    input wire logic acc_load_i,
    input wire logic [DATA_W-1:0] acc_load_data_i,
    // external memory write, used only in cycles where instr_valid_i is low
    input wire logic mem_we_i,
    input wire logic [ADDR_W-1:0] mem_waddr_i,
    input wire logic [DATA_W-1:0] mem_wdata_i,
    // memory observation
    input wire logic [ADDR_W-1:0] obs_addr_i,
    output logic [DATA_W-1:0] obs_data_o,
    // results
    output logic [DATA_W-1:0] acc_o,
    output logic [ST_W-1:0] status_o,
    output logic [ADDR_W-1:0] op_addr_o,
    output logic indexed_o,
    output logic exec_done_o,
    output logic unsupported_o,
    output logic ext_mode_o
);
    logic ext_q;
    logic [DATA_W-1:0] acc_q;
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] status_d;
    logic [DATA_W-1:0] acc_d;
    logic [ADDR_W-1:0] op_addr_q;
    logic indexed_q;
    logic done_q;
    logic unsup_q;
    logic [DATA_W-1:0] obs_q;

    // field decode
    // a picks access bank or bank select, d the destination, b the bit
    wire logic [7:0] field_f = instr_i[OPC_F_MSB:OPC_F_LSB];
    wire logic bit_a = instr_i[OPC_A_BIT];
    wire logic bit_d = instr_i[OPC_D_BIT];
    wire logic [2:0] bit_sel = instr_i[OPC_B_MSB:OPC_B_LSB];

    // operation decode
    wire logic is_add = (instr_i[15:10] == OPC_ADD_HI);
    wire logic is_bset = (instr_i[15:12] == OPC_BSET_HI);
    wire logic is_fill = (instr_i[15:9] == OPC_FILL_HI);
    wire logic is_known = is_add | is_bset | is_fill;
    wire logic run = instr_valid_i & is_known;
    // unknown opcodes only raise the refusal pulse
    wire logic refuse = instr_valid_i & ~is_known;

    wire logic indexed = ext_q & ~bit_a & (field_f <= OFFSET_MAX);

    // the frame pointer is used as it stands in the instruction cycle
    // frame pointer plus offset
    wire logic [ADDR_W:0] idx_sum = {1'b0, stack_frame_pointer_i} + {5'h00, field_f};
    wire logic [ADDR_W-1:0] idx_addr = idx_sum[ADDR_W-1:0];

    // access bank or bank-select address
    // the access bank split moves down to 60h in extended mode
    wire logic [7:0] access_split = ext_q ? ACCESS_SPLIT_EXT : ACCESS_SPLIT_STD;
    wire logic access_high = (field_f >= access_split);
    wire logic [3:0] access_bank = access_high ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK;
    wire logic [ADDR_W-1:0] lit_addr = bit_a ? {bank_select_register_i, field_f}
                                             : {access_bank, field_f};
    wire logic [ADDR_W-1:0] op_addr = indexed ? idx_addr : lit_addr;

    // operand read
    logic [DATA_W-1:0] mem_rd;
    logic [DATA_W-1:0] obs_rd;

    // adder with carry out of bit 7 and bit 3
    wire logic [DATA_W:0] sum9 = {1'b0, acc_q} + {1'b0, mem_rd};
    // low nibble sum gives the carry out of bit 3
    wire logic [4:0] sum_lo = {1'b0, acc_q[3:0]} + {1'b0, mem_rd[3:0]};
    wire logic [DATA_W-1:0] sum8 = sum9[DATA_W-1:0];
    wire logic ovf = (acc_q[7] == mem_rd[7]) & (sum8[7] != acc_q[7]);

    wire logic flag_c = sum9[DATA_W];
    wire logic flag_dig = sum_lo[4];
    wire logic flag_z = (sum8 == 8'h00);
    wire logic flag_n = sum8[7];

    // one-hot bit mask, one compare per data bit
    wire logic [DATA_W-1:0] bit_mask;
    for (genvar i = 0; i < DATA_W; i++) begin : g_mask
        assign bit_mask[i] = (bit_sel == 3'(i));
    end
    // bit set keeps the other bits
    wire logic [DATA_W-1:0] bset_result = mem_rd | bit_mask;

    // result to memory per operation
    // fill with ones
    wire logic [DATA_W-1:0] mem_result = is_add ? sum8 :
                                         is_bset ? bset_result : FILL_VALUE;
    // memory destination when d=1 for the add
    wire logic mem_dest = ~is_add | bit_d;
    wire logic exec_we = run & mem_dest;
    // an external write is dropped in any cycle that carries an instruction
    wire logic ram_we = exec_we | (mem_we_i & ~instr_valid_i);
    wire logic [ADDR_W-1:0] ram_waddr = exec_we ? op_addr : mem_waddr_i;
    wire logic [DATA_W-1:0] ram_wdata = exec_we ? mem_result : mem_wdata_i;

    // the add wins over a load in the same cycle
    wire logic add_exec = run & is_add;
    wire logic acc_from_add = add_exec & ~bit_d;
    wire logic acc_from_load = acc_load_i & ~add_exec;

    ixo_data_ram ixo_data_ram_inst (
        .mclk_i(mclk_i),
        .we_i(ram_we),
        .waddr_i(ram_waddr),
        .wdata_i(ram_wdata),
        .raddr_a_i(op_addr),
        .rdata_a_o(mem_rd),
        .raddr_b_i(obs_addr_i),
        .rdata_b_o(obs_rd)
    );

    // accumulator next value
    always_comb begin
        acc_d = acc_q;
        if (acc_from_add) begin
            acc_d = sum8;
        end else if (acc_from_load) begin
            acc_d = acc_load_data_i;
        end
    end

    // status flags next value
    always_comb begin
        status_d = status_q;
        // only the add touches the flags
        if (add_exec) begin
            status_d[ST_C] = flag_c;
            status_d[ST_DIG] = flag_dig;
            status_d[ST_Z] = flag_z;
            status_d[ST_OVF] = ovf;
            status_d[ST_N] = flag_n;
        end
    end

    // the mode is registered: an instruction right after a change still sees the old mode
    // configuration bit is off out of reset
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ext_q <= EXT_RST;
        end else begin
            ext_q <= extended_set_config_bit_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            acc_q <= ACC_RST;
            status_q <= STATUS_RST;
        end else begin
            acc_q <= acc_d;
            status_q <= status_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            op_addr_q <= '0;
            indexed_q <= 1'b0;
            done_q <= 1'b0;
            unsup_q <= 1'b0;
        end else begin
            if (run) begin
                op_addr_q <= op_addr;
                indexed_q <= indexed;
            end
            done_q <= run;
            unsup_q <= refuse;
        end
    end

    // observation path, one cycle behind the memory
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            obs_q <= '0;
        end else begin
            obs_q <= obs_rd;
        end
    end

    // every output comes straight from a register
    assign acc_o = acc_q;
    assign status_o = status_q;
    assign op_addr_o = op_addr_q;
    assign indexed_o = indexed_q;
    assign exec_done_o = done_q;
    assign unsupported_o = unsup_q;
    assign ext_mode_o = ext_q;
    assign obs_data_o = obs_q;
endmodule

//--- testbench/ixo_decode_chk.sv
// port assertions for the indexed offset operand decoder
`timescale 1ns/1ps
module ixo_decode_chk
    import ixo_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // inputs
    input wire logic extended_set_config_bit_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [ADDR_W-1:0] stack_frame_pointer_i,
    input wire logic [3:0] bank_select_register_i,
    input wire logic acc_load_i,
    // outputs
    input wire logic [DATA_W-1:0] acc_o,
    input wire logic [ST_W-1:0] status_o,
    input wire logic [ADDR_W-1:0] op_addr_o,
    input wire logic indexed_o,
    input wire logic exec_done_o,
    input wire logic unsupported_o,
    input wire logic ext_mode_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    wire logic is_add = instr_valid_i && instr_i[15:10] == OPC_ADD_HI;
    wire logic is_bset = instr_valid_i && instr_i[15:12] == OPC_BSET_HI;
    wire logic is_keep = is_bset || (instr_valid_i && instr_i[15:9] == OPC_FILL_HI);
    wire logic is_rec = is_add || is_keep;
    wire logic is_low = !instr_i[OPC_A_BIT] && instr_i[7:0] <= OFFSET_MAX;
    sequence done_s;
        exec_done_o && !unsupported_o;
    endsequence
    cfg_copy_a: assert property (1'b1 |=> ext_mode_o == $past(extended_set_config_bit_i))
        else $error("config copy wrong");
    one_cycle_a: assert property (is_rec |=> done_s)
        else $error("no completion pulse");
    refuse_op_a: assert property (instr_valid_i && !is_rec |=> unsupported_o && $stable(status_o))
        else $error("unknown opcode not refused");
    idle_quiet_a: assert property (!instr_valid_i |=> !exec_done_o && !unsupported_o)
        else $error("pulse without instruction");
    frame_addr_a: assert property (is_rec && ext_mode_o && is_low |=>
        indexed_o && op_addr_o == $past(stack_frame_pointer_i + instr_i[7:0]))
        else $error("frame address wrong");
    bank_addr_a: assert property (is_rec && instr_i[OPC_A_BIT] |=> !indexed_o &&
        op_addr_o == {$past(bank_select_register_i), $past(instr_i[7:0])})
        else $error("bank address wrong");
    std_access_a: assert property (is_rec && !ext_mode_o && !instr_i[OPC_A_BIT] |=>
        !indexed_o && op_addr_o[11:8] == ($past(instr_i[7]) ? 4'hf : 4'h0))
        else $error("access bank address wrong");
    flags_kept_a: assert property (is_keep |=> $stable(status_o))
        else $error("flags changed");
    add_flags_a: assert property (is_add && !instr_i[OPC_D_BIT] |=>
        status_o[ST_Z] == (acc_o == 8'h00) && status_o[ST_N] == acc_o[7])
        else $error("add flags wrong");
    acc_kept_a: assert property (is_add && instr_i[OPC_D_BIT] && !acc_load_i |=> $stable(acc_o))
        else $error("accumulator changed");
endmodule
bind ixo_decode ixo_decode_chk ixo_decode_chk_inst (.*);

//--- testbench/indexed_offset_operand_decode_bench.sv
// self-checking bench for the indexed offset operand decoder
`timescale 1ns/1ps
module indexed_offset_operand_decode_bench;
    logic mclk_i = 0;
    logic sys_rst_i = 1;
    logic cfg = 0, vld = 0, ald = 0, mwe = 0;
    logic [15:0] op = '0;
    logic [11:0] fp = '0, adr = '0, opa;
    logic [7:0] dat = '0, obd, acc;
    logic [3:0] bank_sel = '0;
    logic [4:0] st;
    logic idx, done, uns, xm;
    int miscompares = 0, checked = 0;
    always #25 mclk_i = ~mclk_i;
    ixo_decode ixo_decode_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .extended_set_config_bit_i(cfg), .instr_valid_i(vld), .instr_i(op),
        .stack_frame_pointer_i(fp), .bank_select_register_i(bank_sel), .acc_load_i(ald),
        .acc_load_data_i(dat), .mem_we_i(mwe), .mem_waddr_i(adr), .mem_wdata_i(dat),
        .obs_addr_i(adr), .obs_data_o(obd), .acc_o(acc), .status_o(st), .op_addr_o(opa),
        .indexed_o(idx), .exec_done_o(done), .unsupported_o(uns), .ext_mode_o(xm));
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one cycle of stimulus from a falling edge to the next
    task automatic step(input logic v, l, w, input logic [15:0] o, input logic [11:0] a,
                        input logic [7:0] d);
        vld = v;
        ald = l;
        mwe = w;
        op = o;
        adr = a;
        dat = d;
        @(negedge mclk_i);
    endtask
    task automatic ins(input logic [15:0] o);
        step(1, 0, 0, o, adr, 8'h00);
        cmp(12'(done), 12'h001);
    endtask
    task automatic peek(input logic [11:0] a, input logic [7:0] e);
        step(0, 0, 0, 16'h0000, a, 8'h00);
        cmp(12'(obd), 12'(e));
    endtask
    initial begin
        #100us;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(negedge mclk_i);
        sys_rst_i = 0;
        cmp(12'(xm), 12'h000);
        cmp(12'(acc), 12'h000);
        fp = 12'ha00;
        bank_sel = 4'h5;
        step(0, 0, 1, 16'h0000, 12'h02c, 8'h20);
        step(0, 1, 0, 16'h0000, 12'h000, 8'h17);
        ins(16'h242c);
        cmp(12'(acc), 12'h037);
        cmp(opa, 12'h02c);
        ins(16'h6910);
        peek(12'h510, 8'hff);
        ins(16'h6890);
        cmp(opa, 12'hf90);
        cmp(12'(idx), 12'h000);
        $display("standard mode test done");
        cfg = 1;
        step(0, 0, 1, 16'h0000, 12'ha2c, 8'h20);
        cmp(12'(xm), 12'h001);
        step(0, 1, 0, 16'h0000, 12'h000, 8'h17);
        ins(16'h242c);
        cmp(12'(acc), 12'h037);
        cmp(opa, 12'ha2c);
        cmp(12'(idx), 12'h001);
        ins(16'h262c);
        peek(12'ha2c, 8'h57);
        cmp(12'(acc), 12'h037);
        $display("indexed add test done");
        step(0, 0, 1, 16'h0000, 12'ha00, 8'h80);
        step(0, 1, 0, 16'h0000, 12'h000, 8'h80);
        ins(16'h2400);
        cmp(12'(st), 12'h00d);
        step(0, 1, 0, 16'h0000, 12'h000, 8'h39);
        ins(16'h242c);
        cmp(12'(st), 12'h01a);
        cmp(12'(acc), 12'h090);
        step(0, 0, 1, 16'h0000, 12'ha0a, 8'h55);
        ins(16'h8e0a);
        ins(16'h682c);
        peek(12'ha0a, 8'hd5);
        peek(12'ha2c, 8'hff);
        cmp(12'(st), 12'h01a);
        $display("flag test done");
        ins(16'h685f);
        cmp(opa, 12'ha5f);
        ins(16'h6860);
        cmp(opa, 12'hf60);
        cmp(12'(idx), 12'h000);
        fp = 12'hff0;
        ins(16'h6820);
        cmp(opa, 12'h010);
        step(1, 0, 0, 16'hffff, 12'h010, 8'h00);
        cmp(12'(uns), 12'h001);
        peek(12'h010, 8'hff);
        $display("boundary test done");
        report_and_stop();
    end
endmodule
